// ===== serial_port_pkg.sv
// Register map, field positions and reset values of the synchronous slave serial port.
package serial_port_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] BAUD_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] RECEIVE_STATUS_ADDR = 8'h04;
    localparam logic [7:0] TRANSMIT_HOLDING_ADDR = 8'h08;
    localparam logic [7:0] TRANSMIT_STATUS_ADDR = 8'h0c;
    localparam logic [7:0] RECEIVE_DATA_ADDR = 8'h10;
    localparam logic [7:0] INTERRUPT_CONTROL_ADDR = 8'h14;

    // Receive control and status fields.
    localparam int PORT_ENABLE_BIT = 7;
    localparam int NINE_BIT_RECEIVE_BIT = 6;
    localparam int SINGLE_RECEIVE_BIT = 5;
    localparam int CONTINUOUS_RECEIVE_BIT = 4;
    localparam int OVERRUN_BIT = 1;
    localparam int RECEIVE_NINTH_BIT = 0;

    // Transmit control and status fields.
    localparam int CLOCK_SOURCE_BIT = 7;
    localparam int NINE_BIT_TRANSMIT_BIT = 6;
    localparam int TRANSMIT_ENABLE_BIT = 5;
    localparam int SYNC_SELECT_BIT = 4;
    localparam int SHIFT_EMPTY_BIT = 1;
    localparam int TRANSMIT_NINTH_BIT = 0;

    // Baud control fields.
    localparam int RECEIVE_IDLE_BIT = 6;
    localparam int CLOCK_POLARITY_BIT = 4;

    // Interrupt control fields.
    localparam int GLOBAL_ENABLE_BIT = 7;
    localparam int PERIPHERAL_ENABLE_BIT = 6;
    localparam int RECEIVE_IE_BIT = 5;
    localparam int TRANSMIT_IE_BIT = 4;
    localparam int RECEIVE_FLAG_BIT = 1;
    localparam int TRANSMIT_FLAG_BIT = 0;

    // Character lengths and bus answers.
    localparam logic [3:0] SHORT_CHAR_BITS = 4'h8;
    localparam logic [3:0] LONG_CHAR_BITS = 4'h9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
endpackage

// ===== receive_fifo.sv
// Small shifting FIFO whose head entry is a register.
`timescale 1ns/1ps
module receive_fifo
    import serial_port_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Write side.
    input wire logic push,
    input wire logic [WIDTH-1:0] pushData,
    // Read side.
    input wire logic pop,
    output logic [WIDTH-1:0] headData,
    output logic notEmpty,
    output logic full
);
    initial begin
        if (DEPTH < 2 || DEPTH > 15) begin
            $error("receive_fifo depth out of range");
        end
    end

    logic [WIDTH-1:0] slot [DEPTH];
    logic [3:0] count;
    logic doPush;
    logic doPop;

    assign doPop = pop && (count != 4'h0);
    assign doPush = push && (count != 4'(DEPTH) || doPop);
    assign headData = slot[0];
    assign notEmpty = count != 4'h0;
    assign full = count == 4'(DEPTH);

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= 4'h0;
        end else begin
            count <= count + {3'h0, doPush} - {3'h0, doPop};
        end
    end

    // Entries move toward the head on a pop; a push lands behind the last entry.
    // Slots clear on reset so status read from an empty buffer is zero, not unknown.
    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (rst) begin
                slot[i] <= {WIDTH{1'h0}};
            end else if (doPush && 4'(i) == count - {3'h0, doPop}) begin
                slot[i] <= pushData;
            end else if (doPop && i < DEPTH - 1) begin
                slot[i] <= slot[i + 1];
            end
        end
    end
endmodule

// ===== usart_sync_slave_link.sv
// Synchronous slave serial port with AXI4-Lite registers.
//
// Operation
// - slave when sync, slave clock, enabled
// - first write loads shifter, second stays held
// - held character loads after shift; flag sets
// - transmit flag with enables raises wake
// - slave receive always continuous, single ignored; here single receive still selects receive mode
// - sleep reception completes into data register
// - receive enable lets completion wake core
// - only slave mode shifts during sleep
// - shifters move only on external clock
// - accept pins asleep; flag on word
// - last bit out loads holding, sets flag
// - writing holding register clears transmit flag
// - global enable selects vectored interrupt wake
// - overrun cleared by receive or port disable
// - change on leading, sample on trailing edge
// - clock pin driver always off
// - two-deep receive buffer, third sets overrun
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module usart_sync_slave_link
    import serial_port_pkg::*;
#(
    parameter int RX_DEPTH = 2
) (
    // System clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Core state.
    input wire logic coreSleep,
    output logic wakeRequest,
    output logic vectorRequest,
    // Serial clock pin.
    input wire logic clockPinIn,
    output logic clockPinOut,
    output logic clockPinOe,
    // Serial data pin.
    input wire logic dataPinIn,
    output logic dataPinOut,
    output logic dataPinOe,
    // AXI4-Lite write address and data.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    initial begin
        if (RX_DEPTH != 2) begin
            $error("receive buffer depth must be two");
        end
    end

    function automatic logic mapped(input logic [7:0] addr);
        mapped = addr == BAUD_CONTROL_ADDR || addr == RECEIVE_STATUS_ADDR
            || addr == TRANSMIT_HOLDING_ADDR || addr == TRANSMIT_STATUS_ADDR
            || addr == RECEIVE_DATA_ADDR || addr == INTERRUPT_CONTROL_ADDR;
    endfunction

    function automatic logic [3:0] charBits(input logic nineBit);
        charBits = nineBit ? LONG_CHAR_BITS : SHORT_CHAR_BITS;
    endfunction

    // Control registers.
    logic [7:0] receiveControl;
    logic [7:0] transmitControl;
    logic [7:0] baudControl;
    logic [7:0] interruptControl;

    // Bus handshake state.
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic wLane0;
    logic awHeld;
    logic wHeld;
    logic awTake;
    logic wTake;
    logic arTake;
    logic doWrite;
    logic next_awHeld;
    logic next_wHeld;

    // Serial state.
    logic [2:0] clockSync;
    logic [2:0] dataSync;
    logic leadingEdge;
    logic trailingEdge;
    logic portEnable;
    logic slaveMode;
    logic receiveMode;
    logic portReset;
    logic shiftAllowed;
    logic [8:0] holding;
    logic holdFull;
    logic [8:0] txShift;
    logic [3:0] txCount;
    logic txBusy;
    logic txDone;
    logic transmitFlag;
    logic [8:0] rxShift;
    logic [3:0] rxCount;
    logic rxComplete;
    logic overrun;
    logic fifoPop;
    logic [8:0] fifoHead;
    logic fifoNotEmpty;
    logic fifoFull;
    logic holdWrite;

    assign portEnable = receiveControl[PORT_ENABLE_BIT];
    assign slaveMode = portEnable && transmitControl[SYNC_SELECT_BIT]
        && !transmitControl[CLOCK_SOURCE_BIT];
    // Single receive counts only as a mode select here; reception never stops on it.
    assign receiveMode = receiveControl[CONTINUOUS_RECEIVE_BIT]
        || receiveControl[SINGLE_RECEIVE_BIT];
    assign portReset = sys_rst || !portEnable;
    // Other modes would need the system clock, so they never shift while asleep.
    assign shiftAllowed = slaveMode && (!coreSleep || slaveMode);

    // The clock pin is sampled through three flops; an edge counts once stages two and three
    // disagree, so the first stage feeds nothing but the second.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clockSync <= 3'h0;
            dataSync <= 3'h0;
        end else begin
            clockSync <= {clockSync[1:0], clockPinIn};
            dataSync <= {dataSync[1:0], dataPinIn};
        end
    end

    // Polarity bit picks which pin edge leads.
    assign leadingEdge = (clockSync[1] != clockSync[2])
        && (clockSync[1] != baudControl[CLOCK_POLARITY_BIT]);
    assign trailingEdge = (clockSync[1] != clockSync[2])
        && (clockSync[1] == baudControl[CLOCK_POLARITY_BIT]);

    // AXI4-Lite slave: address and data are held separately and may arrive in either order.
    assign awTake = s_axi_awvalid && s_axi_awready;
    assign wTake = s_axi_wvalid && s_axi_wready;
    assign arTake = s_axi_arvalid && s_axi_arready;
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign next_awHeld = doWrite ? 1'b0 : (awHeld || awTake);
    assign next_wHeld = doWrite ? 1'b0 : (wHeld || wTake);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awAddr <= 8'h00;
            wData <= 32'h0;
            wLane0 <= 1'b0;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            s_axi_awready <= !next_awHeld;
            s_axi_wready <= !next_wHeld;
            if (awTake) begin
                awAddr <= s_axi_awaddr;
            end
            if (wTake) begin
                wData <= s_axi_wdata;
                wLane0 <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Only byte lane 0 carries register bits; a write without it changes nothing.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            receiveControl <= CONTROL_RESET;
            transmitControl <= CONTROL_RESET;
            baudControl <= CONTROL_RESET;
            interruptControl <= CONTROL_RESET;
        end else if (doWrite && wLane0) begin
            if (awAddr == RECEIVE_STATUS_ADDR) begin
                receiveControl <= wData[7:0];
            end else if (awAddr == TRANSMIT_STATUS_ADDR) begin
                transmitControl <= wData[7:0];
            end else if (awAddr == BAUD_CONTROL_ADDR) begin
                baudControl <= wData[7:0];
            end else if (awAddr == INTERRUPT_CONTROL_ADDR) begin
                interruptControl <= wData[7:0];
            end
        end
    end

    assign holdWrite = doWrite && wLane0 && awAddr == TRANSMIT_HOLDING_ADDR;
    assign fifoPop = arTake && s_axi_araddr == RECEIVE_DATA_ADDR;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !(arTake || (s_axi_rvalid && !s_axi_rready));
            if (arTake) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
                s_axi_rdata <= 32'h0;
                if (s_axi_araddr == RECEIVE_STATUS_ADDR) begin
                    s_axi_rdata[7:2] <= receiveControl[7:2];
                    s_axi_rdata[OVERRUN_BIT] <= overrun;
                    s_axi_rdata[RECEIVE_NINTH_BIT] <= fifoHead[8];
                end else if (s_axi_araddr == TRANSMIT_STATUS_ADDR) begin
                    s_axi_rdata[7:2] <= transmitControl[7:2];
                    s_axi_rdata[SHIFT_EMPTY_BIT] <= !txBusy;
                    s_axi_rdata[TRANSMIT_NINTH_BIT] <= transmitControl[TRANSMIT_NINTH_BIT];
                end else if (s_axi_araddr == BAUD_CONTROL_ADDR) begin
                    s_axi_rdata[CLOCK_POLARITY_BIT] <= baudControl[CLOCK_POLARITY_BIT];
                    s_axi_rdata[RECEIVE_IDLE_BIT] <= rxCount == 4'h0;
                end else if (s_axi_araddr == INTERRUPT_CONTROL_ADDR) begin
                    s_axi_rdata[7:2] <= interruptControl[7:2];
                    s_axi_rdata[RECEIVE_FLAG_BIT] <= fifoNotEmpty;
                    s_axi_rdata[TRANSMIT_FLAG_BIT] <= transmitFlag;
                end else if (s_axi_araddr == RECEIVE_DATA_ADDR) begin
                    s_axi_rdata[7:0] <= fifoHead[7:0];
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Transmit path. The character is done once the trailing edge of its last bit has passed.
    assign txDone = txBusy && trailingEdge
        && txCount == charBits(transmitControl[NINE_BIT_TRANSMIT_BIT]);

    always_ff @(posedge core_clk) begin
        if (portReset) begin
            holding <= 9'h0;
            holdFull <= 1'b0;
            txShift <= 9'h0;
            txCount <= 4'h0;
            txBusy <= 1'b0;
            dataPinOut <= 1'b0;
        end else begin
            if (holdWrite) begin
                // Ninth bit is taken from the control register when the low byte lands.
                holding <= {transmitControl[TRANSMIT_NINTH_BIT], wData[7:0]};
                holdFull <= 1'b1;
            end
            if (!txBusy && holdFull && transmitControl[TRANSMIT_ENABLE_BIT]) begin
                txShift <= holding;
                txBusy <= 1'b1;
                txCount <= 4'h0;
                holdFull <= holdWrite;
            end else if (txDone) begin
                txBusy <= holdFull;
                txCount <= 4'h0;
                if (holdFull) begin
                    txShift <= holding;
                    holdFull <= holdWrite;
                end
            end else if (txBusy && shiftAllowed && leadingEdge
                && txCount != charBits(transmitControl[NINE_BIT_TRANSMIT_BIT])) begin
                dataPinOut <= txShift[0];
                txShift <= {1'b0, txShift[8:1]};
                txCount <= txCount + 4'h1;
            end
        end
    end

    // The flag shows a free holding register; a write fills it and drops the flag.
    always_ff @(posedge core_clk) begin
        if (portReset) begin
            transmitFlag <= 1'b0;
        end else begin
            transmitFlag <= transmitControl[TRANSMIT_ENABLE_BIT] && !holdWrite
                && (!holdFull || txDone || !txBusy);
        end
    end

    // Receive path, sampled on the trailing edge, least significant bit first.
    assign rxComplete = trailingEdge && slaveMode && receiveMode && !overrun
        && rxCount == charBits(receiveControl[NINE_BIT_RECEIVE_BIT]) - 4'h1;

    always_ff @(posedge core_clk) begin
        if (portReset || !receiveMode) begin
            rxShift <= 9'h0;
            rxCount <= 4'h0;
        end else if (rxComplete) begin
            rxCount <= 4'h0;
        end else if (trailingEdge && shiftAllowed && !overrun) begin
            rxShift <= {dataSync[2], rxShift[8:1]};
            rxCount <= rxCount + 4'h1;
        end
    end

    // A full buffer refuses the third character; only dropping continuous receive or the
    // port itself recovers, so software cannot clear it by reading alone.
    always_ff @(posedge core_clk) begin
        if (portReset || !receiveControl[CONTINUOUS_RECEIVE_BIT]) begin
            overrun <= 1'b0;
        end else if (rxComplete && fifoFull && !fifoPop) begin
            overrun <= 1'b1;
        end
    end

    receive_fifo #(
        .WIDTH(9),
        .DEPTH(RX_DEPTH)
    ) u_receive_fifo (
        .clk(core_clk),
        .rst(portReset),
        .push(rxComplete && !(fifoFull && !fifoPop)),
        .pushData(receiveControl[NINE_BIT_RECEIVE_BIT] ? {dataSync[2], rxShift[8:1]}
            : {1'b0, dataSync[2], rxShift[8:2]}),
        .pop(fifoPop),
        .headData(fifoHead),
        .notEmpty(fifoNotEmpty),
        .full(fifoFull)
    );

    // Wake and vectored interrupt requests.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wakeRequest <= 1'b0;
            vectorRequest <= 1'b0;
        end else begin
            wakeRequest <= (transmitFlag && interruptControl[TRANSMIT_IE_BIT]
                && interruptControl[PERIPHERAL_ENABLE_BIT])
                || (fifoNotEmpty && interruptControl[RECEIVE_IE_BIT]);
            vectorRequest <= ((transmitFlag && interruptControl[TRANSMIT_IE_BIT]
                && interruptControl[PERIPHERAL_ENABLE_BIT])
                || (fifoNotEmpty && interruptControl[RECEIVE_IE_BIT]))
                && interruptControl[GLOBAL_ENABLE_BIT];
        end
    end

    // The data pin is driven only while transmitting as a slave; the clock pin never is.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dataPinOe <= 1'b0;
            clockPinOe <= 1'b0;
            clockPinOut <= 1'b0;
        end else begin
            dataPinOe <= slaveMode && !receiveMode && transmitControl[TRANSMIT_ENABLE_BIT];
            clockPinOe <= 1'b0;
            clockPinOut <= 1'b0;
        end
    end
endmodule

// ===== usart_sync_slave_link_properties.sv
// Concurrent checks on the serial port's pins, wake outputs and register bus handshakes.
`timescale 1ns/1ps
module usart_sync_slave_link_properties (
    // Clock, reset and wake outputs.
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wakeRequest,
    input wire logic vectorRequest,
    // Serial pins.
    input wire logic clockPinIn,
    input wire logic clockPinOut,
    input wire logic clockPinOe,
    input wire logic dataPinOut,
    input wire logic dataPinOe,
    // Register bus handshakes.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    property p_clockDriverOff; !clockPinOe && !clockPinOut; endproperty
    a_clockDriverOff: assert property (p_clockDriverOff) else $error("clock pin driven");
    property p_vectorNeedsWake; vectorRequest |-> wakeRequest; endproperty
    a_vectorNeedsWake: assert property (p_vectorNeedsWake) else $error("vector without wake");
    // The bit must stand for three core clock cycles after the clock pin falls, or the master samples a change.
    property p_dataHold; $fell(clockPinIn) && dataPinOe |=> $stable(dataPinOut) [*3]; endproperty
    a_dataHold: assert property (p_dataHold) else $error("data moved near trailing edge");
    property p_resetQuiet; $fell(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid && !wakeRequest; endproperty
    a_resetQuiet: assert property (p_resetQuiet) else $error("outputs busy after reset");
    property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bHold: assert property (p_bHold) else $error("write response dropped");
    property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp); endproperty
    a_rHold: assert property (p_rHold) else $error("read response dropped");
    property p_arLow; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arLow: assert property (p_arLow) else $error("read address ready while answering");
    property p_writeAnswer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_writeAnswer: assert property (p_writeAnswer) else $error("write response late");
    property p_readAnswer; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
    a_readAnswer: assert property (p_readAnswer) else $error("read data late");
endmodule

// ===== sync_master_model.sv
// External synchronous master that clocks characters into and out of the slave port.
`timescale 1ns/1ps
module sync_master_model (
    // Link pins as the master sees them.
    output logic serialClock,
    output logic serialData,
    input wire logic lineData
);
    initial begin
        serialClock = 1'h0;
        serialData = 1'h0;
    end
    // The clock stands low between frames; rising edges lead, falling edges trail.
    task automatic frame(input int nBits, input logic [8:0] sendWord, output logic [8:0] seen);
        seen = 9'h000;
        #30;
        for (int i = 0; i < nBits; i++) begin
            serialClock = 1'h1;
            serialData = sendWord[i];
            #400;
            serialClock = 1'h0;
            seen[i] = lineData;
            #400;
        end
        // A stale bit must never pass for data once the frame is over.
        serialData = ~serialData;
        #800;
    endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the synchronous slave serial port.
`timescale 1ns/1ps
module tb_top
    import serial_port_pkg::*;
;
    logic core_clk = 1'h0, sys_rst = 1'h1, coreSleep = 1'h0;
    logic clockPinIn, masterData, dataPinIn, wakeRequest, vectorRequest;
    logic clockPinOut, clockPinOe, dataPinOut, dataPinOe;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int nErrors = 0, nTests = 0;

    assign dataPinIn = dataPinOe ? dataPinOut : masterData;
    usart_sync_slave_link i_usart_sync_slave_link (
        .core_clk, .sys_rst, .coreSleep, .wakeRequest, .vectorRequest, .clockPinIn,
        .clockPinOut, .clockPinOe, .dataPinIn, .dataPinOut, .dataPinOe, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );
    sync_master_model i_sync_master_model (
        .serialClock(clockPinIn),
        .serialData(masterData),
        .lineData(dataPinIn)
    );

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] expected, input logic [31:0] seen);
        nTests++;
        if (seen !== expected) begin
            nErrors++;
            $display("ERROR %s expected %h seen %h", what, expected, seen);
        end
    endtask

    task automatic regWrite(input logic [7:0] addr, input logic [7:0] data,
            input logic [1:0] resp = RESP_OKAY);
        s_axi_awaddr <= addr;
        s_axi_wdata <= {24'h000000, data};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        check($sformatf("write response %h", addr), {30'h0, resp}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'h0;
        @(posedge core_clk);
    endtask

    // Response code and data byte are judged together in one comparison.
    task automatic regExpect(input logic [7:0] addr, input logic [7:0] expected,
            input logic [1:0] resp = RESP_OKAY);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        check($sformatf("read %h", addr), {resp, 22'h0, expected}, {s_axi_rresp, s_axi_rdata[29:0]});
        s_axi_rready <= 1'h0;
        @(posedge core_clk);
    endtask

    task automatic pinExpect(input logic wake, input logic vector);
        check("wake request", {31'h0, wake}, {31'h0, wakeRequest});
        check("vector request", {31'h0, vector}, {31'h0, vectorRequest});
    endtask

    task automatic linkFrame(input int nBits, input logic [8:0] word, input bit isTransmit);
        logic [8:0] seen;
        i_sync_master_model.frame(nBits, word, seen);
        @(posedge core_clk);
        if (isTransmit) check("serial word", {23'h0, word}, {23'h0, seen});
    endtask

    task automatic testResetAndMap;
        regExpect(RECEIVE_STATUS_ADDR, CONTROL_RESET);
        regExpect(TRANSMIT_STATUS_ADDR, 8'h02);
        regExpect(INTERRUPT_CONTROL_ADDR, 8'h00);
        regExpect(BAUD_CONTROL_ADDR, 8'h40);
        regWrite(BAUD_CONTROL_ADDR, 8'h10);
        regExpect(BAUD_CONTROL_ADDR, 8'h50);
        regWrite(BAUD_CONTROL_ADDR, 8'h00);
        regExpect(TRANSMIT_HOLDING_ADDR, 8'h00);
        regExpect(8'h18, 8'h00, RESP_SLVERR);
        regWrite(8'h1c, 8'hff, RESP_SLVERR);
    endtask

    task automatic testReceive;
        regWrite(TRANSMIT_STATUS_ADDR, 8'h10);
        regWrite(INTERRUPT_CONTROL_ADDR, 8'h20);
        regWrite(RECEIVE_STATUS_ADDR, 8'h90);
        coreSleep <= 1'h1;
        linkFrame(8, 9'h0a5, 1'b0);
        pinExpect(1'h1, 1'h0);
        linkFrame(8, 9'h03c, 1'b0);
        linkFrame(8, 9'h077, 1'b0);
        coreSleep <= 1'h0;
        regExpect(RECEIVE_STATUS_ADDR, 8'h92);
        regExpect(INTERRUPT_CONTROL_ADDR, 8'h22);
        regExpect(RECEIVE_DATA_ADDR, 8'ha5);
        regExpect(RECEIVE_DATA_ADDR, 8'h3c);
        regExpect(INTERRUPT_CONTROL_ADDR, 8'h20);
        pinExpect(1'h0, 1'h0);
        regWrite(RECEIVE_STATUS_ADDR, 8'h80);
        regExpect(RECEIVE_STATUS_ADDR, 8'h80);
    endtask

    task automatic testNineBitReceive;
        regWrite(INTERRUPT_CONTROL_ADDR, 8'ha0);
        regWrite(RECEIVE_STATUS_ADDR, 8'hd0);
        linkFrame(9, 9'h1c3, 1'b0);
        pinExpect(1'h1, 1'h1);
        regExpect(RECEIVE_STATUS_ADDR, 8'hd1);
        regExpect(RECEIVE_DATA_ADDR, 8'hc3);
        regWrite(RECEIVE_STATUS_ADDR, 8'h00);
    endtask

    task automatic testTransmit;
        regWrite(RECEIVE_STATUS_ADDR, 8'h80);
        regWrite(INTERRUPT_CONTROL_ADDR, 8'h50);
        regWrite(TRANSMIT_STATUS_ADDR, 8'h30);
        regExpect(INTERRUPT_CONTROL_ADDR, 8'h51);
        regWrite(TRANSMIT_HOLDING_ADDR, 8'h5a);
        regWrite(TRANSMIT_HOLDING_ADDR, 8'h81);
        coreSleep <= 1'h1;
        regExpect(INTERRUPT_CONTROL_ADDR, 8'h50);
        pinExpect(1'h0, 1'h0);
        linkFrame(8, 9'h05a, 1'b1);
        pinExpect(1'h1, 1'h0);
        regWrite(TRANSMIT_HOLDING_ADDR, 8'hc3);
        regExpect(INTERRUPT_CONTROL_ADDR, 8'h50);
        linkFrame(8, 9'h081, 1'b1);
        linkFrame(8, 9'h0c3, 1'b1);
        coreSleep <= 1'h0;
        regWrite(TRANSMIT_STATUS_ADDR, 8'h71);
        regWrite(TRANSMIT_HOLDING_ADDR, 8'h0f);
        linkFrame(9, 9'h10f, 1'b1);
        regWrite(RECEIVE_STATUS_ADDR, 8'h00);
    endtask

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The full run needs about 80 us; the limit leaves generous margin.
    initial begin
        #1000000;
        nErrors++;
        $display("ERROR watchdog expected finish seen timeout");
        summarize();
    end

    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'h0;
        testResetAndMap();
        testReceive();
        testNineBitReceive();
        testTransmit();
        summarize();
    end
endmodule

bind usart_sync_slave_link usart_sync_slave_link_properties i_usart_sync_slave_link_properties (
    .core_clk, .sys_rst, .wakeRequest, .vectorRequest, .clockPinIn, .clockPinOut,
    .clockPinOe, .dataPinOut, .dataPinOe, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
